// ### shared/sir_consts.vh
`ifndef SIR_CONSTS_VH
`define SIR_CONSTS_VH
// Command opcodes.
`define SIR_OP_SYNC 8'h00
`define SIR_OP_SECS 8'h0a
`define SIR_OP_RCAUSE 8'h0b
`define SIR_OP_EVT 8'h0c
`define SIR_OP_CLK 8'h0d
`define SIR_OP_MON 8'h0e
`define SIR_OP_CSUM 8'h0f
`define SIR_OP_ERR 8'h10
`define SIR_OP_EXT 8'h11
`define SIR_OP_EVTNR 8'h1b
// Link characters.
`define SIR_ACK 8'hfe
`define SIR_NAK 8'hfd
`define SIR_INTR 8'hfa
// Reset cause codes.
`define SIR_RC_POWER 3'h1
`define SIR_RC_USER 3'h2
`define SIR_RC_WDOG 3'h3
`define SIR_RC_TMO 3'h4
`define SIR_RC_SOFT 3'h5
`define SIR_RC_BROWN 3'h6
// Event and external status bits.
`define SIR_EVT_ERR 8
`define SIR_EVT_VALID 16'hfdff
`define SIR_EXT_MOUSE 5
`define SIR_EXT_VALID 16'h07ff
// Register byte offsets.
`define SIR_REG_CTRL 8'h00
`define SIR_REG_SECS 8'h04
`define SIR_REG_EVT 8'h08
`define SIR_REG_ERR 8'h0c
`define SIR_REG_RCAUSE 8'h10
`define SIR_REG_CSUM 8'h14
`define SIR_REG_EXT 8'h18
// Reset values.
`define SIR_CTRL_RST 32'h0000_0001
`define SIR_CSUM_RST 16'h0000
// Timing: one second at 250 MHz, write-back period in seconds.
`define SIR_CLK_MHZ 250
`define SIR_SEC_US 1000000
`define SIR_SEC_CYCLES (`SIR_CLK_MHZ * `SIR_SEC_US)
`define SIR_WB_SECS 60
`endif

// ### rtl/sir_top.v
// How it works
// - Seconds opcode returns ack plus four bytes msb-first.
// - Reset-cause opcode returns ack plus one byte.
// - Reset cause caught at reset, held till next.
// - Cause codes one to six; zero, seven reserved.
// - Event opcode returns ack plus sixteen-bit mask.
// - Low event bits are power, battery, peripheral changes.
// - High event bits: error, battery, DC, button.
// - Normal event read clears the reported flags.
// - Second event opcode reads without clearing.
// - Clock opcode returns ack plus seven time bytes.
// - Clock error gives a negative acknowledge.
// - Monitor opcode returns four raw sense bits.
// - Checksum opcode returns ack plus two bytes.
// - Error opcode returns ack plus two fault bytes.
// - Fault sets event bit eight, sends interrupt character.
// - External opcode returns present conditions, sixteen bits.
// - External bits zero to ten are attachment states.
// - Mouse bit sets on packets, clears only at reset.
// - Only one command exchange at a time.
// - Sync opcode echoes sync byte to realign host.
`include "sir_consts.vh"
`default_nettype none

module sir_top #(
   parameter SEC_CYCLES = `SIR_SEC_CYCLES,
   parameter WB_SECS = `SIR_WB_SECS
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire rx_valid,
   input wire [7:0] rx_data,
   output reg tx_valid,
   output reg [7:0] tx_data,
   input wire tx_ready,
   input wire [15:0] evt_pulse,
   input wire fault_pulse,
   input wire [15:0] fault_code,
   input wire [10:0] ext_pins,
   input wire mouse_packet,
   input wire [3:0] monitor_pins,
   input wire [55:0] rtc_time,
   input wire rtc_error,
   input wire [2:0] reset_cause_in,
   output reg nv_wr_valid,
   output reg [31:0] nv_wr_data
);

   localparam ST_IDLE = 1'b0;
   localparam ST_SEND = 1'b1;
   localparam [31:0] SEC_LAST = SEC_CYCLES - 1;
   localparam [15:0] WB_LAST = WB_SECS - 1;

   reg state;
   reg [7:0] msg [0:7];
   reg [2:0] idx;
   reg [2:0] last;
   reg clr_mode;
   reg [15:0] snap;
   reg [15:0] evt_flags;
   reg [15:0] err_code;
   reg irq_pend;
   reg [2:0] reset_cause;
   reg cause_taken;
   reg mouse_seen;
   reg [10:0] ext_meta;
   reg [10:0] ext_sync;
   reg [3:0] mon_meta;
   reg [3:0] mon_sync;
   reg [31:0] seconds;
   reg [31:0] div_cnt;
   reg [15:0] wb_cnt;
   reg [31:0] ctrl;
   reg [15:0] csum;
   reg [7:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;

   wire enable = ctrl[0];
   wire tx_fire = tx_valid && tx_ready;
   wire msg_done = (state == ST_SEND) && tx_fire && (idx == last);
   wire evt_clr = msg_done && clr_mode;
   wire cmd_take = (state == ST_IDLE) && rx_valid && enable;
   wire irq_take = (state == ST_IDLE) && !rx_valid && irq_pend;
   wire sec_tick = (div_cnt == SEC_LAST);
   wire [15:0] evt_set = (evt_pulse | {7'h00, fault_pulse, 8'h00}) & `SIR_EVT_VALID;
   wire [15:0] ext_now = {5'h00, ext_sync[10:6], ext_sync[5] | mouse_seen, ext_sync[4:0]};
   wire do_wr = aw_held && w_held && !s_axi_bvalid;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers for the external status and monitor sense lines.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_meta <= 11'h000;
         ext_sync <= 11'h000;
         mon_meta <= 4'h0;
         mon_sync <= 4'h0;
      end
      else
      begin
         ext_meta <= ext_pins;
         ext_sync <= ext_meta;
         mon_meta <= monitor_pins;
         mon_sync <= mon_meta;
      end
   end

   // The mouse bit stays set once any packet has been seen.
   always @(posedge aclk)
   begin
      if (!aresetn)
         mouse_seen <= 1'b0;
      else if (mouse_packet)
         mouse_seen <= 1'b1;
   end

   // The reset cause is caught at the first edge after release and then held.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reset_cause <= 3'h0;
         cause_taken <= 1'b0;
      end
      else if (!cause_taken)
      begin
         reset_cause <= reset_cause_in;
         cause_taken <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky event flags; a new event beats the clear in the same cycle,
   // and only the bits actually reported to the host are cleared.
   always @(posedge aclk)
   begin
      if (!aresetn)
         evt_flags <= 16'h0000;
      else
         evt_flags <= (evt_flags & ~(snap & {16{evt_clr}})) | evt_set;
   end

   // Fault code register; zero means no error, cleared with event bit eight.
   always @(posedge aclk)
   begin
      if (!aresetn)
         err_code <= 16'h0000;
      else if (fault_pulse)
         err_code <= fault_code;
      else if (evt_clr && snap[`SIR_EVT_ERR])
         err_code <= 16'h0000;
   end

   // Pending interrupt character; a fault in the sending cycle keeps it set.
   always @(posedge aclk)
   begin
      if (!aresetn)
         irq_pend <= 1'b0;
      else if (fault_pulse)
         irq_pend <= 1'b1;
      else if (irq_take)
         irq_pend <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Lifetime seconds counter with periodic write-back to storage.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_cnt <= 32'h0000_0000;
         wb_cnt <= 16'h0000;
         seconds <= 32'h0000_0000;
         nv_wr_valid <= 1'b0;
         nv_wr_data <= 32'h0000_0000;
      end
      else
      begin
         nv_wr_valid <= 1'b0;
         div_cnt <= sec_tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
         if (do_wr && aw_addr == `SIR_REG_SECS)
            seconds <= w_data;
         else if (sec_tick)
            seconds <= seconds + 32'h0000_0001;
         if (sec_tick)
         begin
            wb_cnt <= (wb_cnt == WB_LAST) ? 16'h0000 : wb_cnt + 16'h0001;
            if (wb_cnt == WB_LAST)
            begin
               nv_wr_valid <= 1'b1;
               nv_wr_data <= seconds + 32'h0000_0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command engine: one exchange at a time, bytes taken only while idle.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_IDLE;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         idx <= 3'h0;
         last <= 3'h0;
         clr_mode <= 1'b0;
         snap <= 16'h0000;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               idx <= 3'h0;
               clr_mode <= 1'b0;
               msg[0] <= `SIR_ACK;
               if (cmd_take)
               begin
                  state <= ST_SEND;
                  tx_valid <= 1'b1;
                  tx_data <= `SIR_ACK;
                  case (rx_data)
                     `SIR_OP_SYNC:
                     begin
                        tx_data <= `SIR_OP_SYNC;
                        last <= 3'h0;
                     end
                     `SIR_OP_SECS:
                     begin
                        msg[1] <= seconds[31:24];
                        msg[2] <= seconds[23:16];
                        msg[3] <= seconds[15:8];
                        msg[4] <= seconds[7:0];
                        last <= 3'h4;
                     end
                     `SIR_OP_RCAUSE:
                     begin
                        msg[1] <= {5'h00, reset_cause};
                        last <= 3'h1;
                     end
                     `SIR_OP_EVT, `SIR_OP_EVTNR:
                     begin
                        msg[1] <= evt_flags[15:8];
                        msg[2] <= evt_flags[7:0];
                        snap <= evt_flags;
                        clr_mode <= (rx_data == `SIR_OP_EVT);
                        last <= 3'h2;
                     end
                     `SIR_OP_CLK:
                     begin
                        if (rtc_error)
                        begin
                           tx_data <= `SIR_NAK;
                           last <= 3'h0;
                        end
                        else
                        begin
                           msg[1] <= rtc_time[55:48];
                           msg[2] <= rtc_time[47:40];
                           msg[3] <= rtc_time[39:32];
                           msg[4] <= rtc_time[31:24];
                           msg[5] <= rtc_time[23:16];
                           msg[6] <= rtc_time[15:8];
                           msg[7] <= rtc_time[7:0];
                           last <= 3'h7;
                        end
                     end
                     `SIR_OP_MON:
                     begin
                        msg[1] <= {4'h0, mon_sync};
                        last <= 3'h1;
                     end
                     `SIR_OP_CSUM:
                     begin
                        msg[1] <= csum[15:8];
                        msg[2] <= csum[7:0];
                        last <= 3'h2;
                     end
                     `SIR_OP_ERR:
                     begin
                        msg[1] <= err_code[15:8];
                        msg[2] <= err_code[7:0];
                        last <= 3'h2;
                     end
                     `SIR_OP_EXT:
                     begin
                        msg[1] <= ext_now[15:8];
                        msg[2] <= ext_now[7:0];
                        last <= 3'h2;
                     end
                     default:
                     begin
                        tx_data <= `SIR_NAK;
                        last <= 3'h0;
                     end
                  endcase
               end
               else if (irq_take)
               begin
                  state <= ST_SEND;
                  tx_valid <= 1'b1;
                  tx_data <= `SIR_INTR;
                  last <= 3'h0;
               end
            end
            ST_SEND:
            begin
               if (tx_fire)
               begin
                  if (idx == last)
                  begin
                     tx_valid <= 1'b0;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     tx_data <= msg[idx + 3'h1];
                     idx <= idx + 3'h1;
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side: address and data taken in either order.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         ctrl <= `SIR_CTRL_RST;
         csum <= `SIR_CSUM_RST;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (aw_addr)
               `SIR_REG_CTRL:
                  if (w_strb[0])
                     ctrl <= {31'h0000_0000, w_data[0]};
               `SIR_REG_CSUM:
               begin
                  if (w_strb[0])
                     csum[7:0] <= w_data[7:0];
                  if (w_strb[1])
                     csum[15:8] <= w_data[15:8];
               end
               `SIR_REG_SECS:
                  s_axi_bresp <= 2'h0;
               default:
                  s_axi_bresp <= 2'h2; // Read-only or unmapped.
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read side: one read at a time, answer the cycle after.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `SIR_REG_CTRL: s_axi_rdata <= ctrl;
               `SIR_REG_SECS: s_axi_rdata <= seconds;
               `SIR_REG_EVT: s_axi_rdata <= {16'h0000, evt_flags};
               `SIR_REG_ERR: s_axi_rdata <= {16'h0000, err_code};
               `SIR_REG_RCAUSE: s_axi_rdata <= {29'h0000_0000, reset_cause};
               `SIR_REG_CSUM: s_axi_rdata <= {16'h0000, csum};
               `SIR_REG_EXT: s_axi_rdata <= {16'h0000, ext_now};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ### verif/sir_top_monitor.sv
`default_nettype none
module sir_top_monitor #(
   parameter SEC_CYCLES = 10,
   parameter WB_SECS = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic fault_pulse,
   input wire logic rtc_error,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic nv_wr_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [31:0] nv_gap;
   // Counts cycles since the last write-back pulse.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || nv_wr_valid)
         nv_gap <= 32'h0;
      else
         nv_gap <= nv_gap + 32'h1;
   end
   ////////////////////////////////////////
   // A known opcode other than sync and clock, taken while idle, opens its reply with the acknowledge.
   sequence cmd_seen;
      rx_valid && !tx_valid && rx_data inside {8'h0a, 8'h0b, 8'h0c, 8'h0e,
         8'h0f, 8'h10, 8'h11, 8'h1b} ##1 tx_valid;
   endsequence
   sequence fault_idle;
      fault_pulse && !tx_valid && !rx_valid ##1 !rx_valid;
   endsequence
   AST_CMD_ACK: assert property (cmd_seen |-> tx_data == 8'hfe)
      else $error("reply did not start with acknowledge");
   AST_CLK_NAK: assert property (rx_valid && !tx_valid && rx_data == 8'h0d && rtc_error
      ##1 tx_valid |-> tx_data == 8'hfd) else $error("clock fault not refused");
   AST_SYNC_ECHO: assert property (rx_valid && !tx_valid && rx_data == 8'h00
      ##1 tx_valid |-> tx_data == 8'h00) else $error("sync byte not echoed");
   AST_FAULT_CHAR: assert property (fault_idle |=> tx_valid && tx_data == 8'hfa)
      else $error("fault character missing");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte changed before it was taken");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped early");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_NV_GAP: assert property (nv_wr_valid |-> nv_gap >= SEC_CYCLES * WB_SECS - 2)
      else $error("write-back too soon");
   cover property (tx_valid && tx_ready && tx_data == 8'hfa);
   cover property (tx_valid && tx_ready && tx_data == 8'hfd);
   cover property (nv_wr_valid);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind sir_top sir_top_monitor #(.SEC_CYCLES(SEC_CYCLES), .WB_SECS(WB_SECS)) mon_u (.aclk,
   .aresetn, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready, .fault_pulse, .rtc_error,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .nv_wr_valid);
`default_nettype wire

// ### verif/sir_host.sv
`default_nettype none
module sir_host (
   input wire logic aclk,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic in_phase;
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h55;
      tx_ready = 1'b0;
      in_phase = 1'b0;
   end
   // Takes reply bytes with random stalls; an echoed sync byte marks the link in phase.
   always @(posedge aclk)
   begin
      tx_ready <= ($urandom % 4) != 0;
      if (tx_valid && tx_ready && tx_data == 8'h00)
         in_phase <= 1'b1;
   end
   // Sends one opcode; callers wait for the whole reply before the next one.
   task send(input logic [7:0] op);
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_data <= op;
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_data <= ~op; // A released line must not show a stale opcode.
   endtask
endmodule
`default_nettype wire

// ### verif/tb_system_info_command_responder.sv
`default_nettype none
module tb_system_info_command_responder;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, rx_valid, tx_valid, tx_ready, fault_pulse, mouse_packet;
   logic rtc_error, nv_wr_valid;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data, tx_data;
   logic [31:0] s_axi_wdata, s_axi_rdata, nv_wr_data, v, w;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb, monitor_pins;
   logic [15:0] evt_pulse, fault_code;
   logic [10:0] ext_pins;
   logic [55:0] rtc_time;
   logic [2:0] reset_cause_in;
   logic [63:0] t;
   logic [7:0] eq[$];
   logic [33:0] rq[$];
   int bad_count, comparisons;
   sir_top #(.SEC_CYCLES(5000), .WB_SECS(2)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_data, .tx_valid,
      .tx_data, .tx_ready, .evt_pulse, .fault_pulse, .fault_code, .ext_pins, .mouse_packet,
      .monitor_pins, .rtc_time, .rtc_error, .reset_cause_in, .nv_wr_valid, .nv_wr_data);
   sir_host hst_u (.aclk, .tx_valid, .tx_data, .rx_valid, .rx_data, .tx_ready);
   // Free-running 250 MHz clock.
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Takes the oldest note whenever the design hands over a result.
   always @(posedge aclk)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         check("tx_data", tx_data, eq.size() ? eq.pop_front() : 34'h3ffff);
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         check("bresp", {s_axi_bresp, 32'h0}, rq.pop_front());
   end
   // Stops a hung run.
   initial
   begin
      repeat (60000) @(posedge aclk);
      bad_count++;
      final_report;
   end
   ////////////////////////////////////////
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({r, 32'h0});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   task drain;
      int i;
      for (i = 0; i < 400 && (eq.size() != 0 || tx_valid === 1'b1); i++) @(posedge aclk);
      check("tx_left", eq.size(), 0);
   endtask
   task cmd(input logic [7:0] op, input int n, input logic [63:0] d, input logic [7:0] f = 8'hfe);
      int i;
      eq.push_back(f);
      for (i = n - 1; i >= 0; i--) eq.push_back(d[8*i+:8]);
      hst_u.send(op);
      drain;
   endtask
   task rst(input logic [2:0] c);
      @(posedge aclk);
      aresetn <= 1'b0;
      reset_cause_in <= c;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      reset_cause_in <= 3'h7; // Later changes must not reach the latched cause.
   endtask
   task nv_wait(output logic [31:0] d);
      int i;
      for (i = 0; i < 12000 && nv_wr_valid !== 1'b1; i++) @(posedge aclk);
      d = nv_wr_data;
      @(posedge aclk);
   endtask
   ////////////////////////////////////////
   // Main sequence: every reset cause, registers, then each opcode in turn.
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, evt_pulse, fault_pulse, fault_code} = '0;
      {ext_pins, mouse_packet, monitor_pins, rtc_time, rtc_error, reset_cause_in} = '0;
      s_axi_wstrb = 4'hf;
      void'($urandom(23704));
      for (int c = 1; c <= 6; c++)
      begin
         rst(c[2:0]);
         cmd(8'h0b, 1, c);
      end
      $display("test reset_cause done");
      axi_rd(8'h00, 34'h1);
      axi_rd(8'h14, 34'h0);
      axi_rd(8'h1c, {2'b10, 32'h0});
      axi_wr(8'h08, 32'hffff, 2'b10);
      v = $urandom;
      axi_wr(8'h04, v, 2'b00);
      cmd(8'h0a, 4, v);
      axi_wr(8'h14, v, 2'b00);
      axi_rd(8'h14, {18'h0, v[15:0]});
      cmd(8'h0f, 2, v[15:0]);
      $display("test registers done");
      v = $urandom & 32'hfdff;
      evt_pulse <= v[15:0];
      @(posedge aclk) evt_pulse <= 16'h0;
      repeat (2) @(posedge aclk);
      cmd(8'h1b, 2, v[15:0]);
      cmd(8'h1b, 2, v[15:0]);
      cmd(8'h0c, 2, v[15:0]);
      cmd(8'h0c, 2, 0);
      $display("test events done");
      v = $urandom | 32'h1;
      eq.push_back(8'hfa);
      fault_pulse <= 1'b1;
      fault_code <= v[15:0];
      @(posedge aclk) fault_pulse <= 1'b0;
      drain;
      cmd(8'h10, 2, v[15:0]);
      cmd(8'h0c, 2, 16'h0100);
      cmd(8'h10, 2, 0);
      $display("test fault done");
      t = {$urandom, $urandom};
      rtc_time <= t[55:0];
      cmd(8'h0d, 7, t[55:0]);
      rtc_error <= 1'b1;
      cmd(8'h0d, 0, 0, 8'hfd);
      rtc_error <= 1'b0;
      v = $urandom;
      monitor_pins <= v[3:0];
      ext_pins <= v[14:4] & 11'h7df;
      repeat (4) @(posedge aclk);
      cmd(8'h0e, 1, v[3:0]);
      cmd(8'h11, 2, v[14:4] & 11'h7df);
      mouse_packet <= 1'b1;
      @(posedge aclk) mouse_packet <= 1'b0;
      cmd(8'h11, 2, v[14:4] | 11'h020);
      cmd(8'h00, 0, 0, 8'h00);
      check("in_phase", hst_u.in_phase, 34'h1);
      cmd(8'h20, 0, 0, 8'hfd);
      $display("test opcodes done");
      axi_wr(8'h00, 32'h0, 2'b00);
      hst_u.send(8'h0b);
      repeat (10) @(posedge aclk);
      drain;
      axi_wr(8'h00, 32'h1, 2'b00);
      cmd(8'h0b, 1, 6);
      $display("test disable done");
      nv_wait(v);
      nv_wait(w);
      check("nv_data", w, v + 32'h2);
      $display("test writeback done");
      final_report;
   end
endmodule
`default_nettype wire
